//--- src/mbs_crc16.sv
// Check register, one byte per clock.
module mbs_crc16 import mbs_pkg::*; (
   input  wire logic        clock,     // System clock.
   input  wire logic        rst,       // Synchronous reset, active high.
   input  wire logic        clear,     // Reload the start value.
   input  wire logic        byteValid, // Fold byteIn in this cycle.
   input  wire logic [7:0]  byteIn,    // Frame byte in link order.
   output logic      [15:0] crcReg     // Current check value.
);

   logic [15:0] crcNext;

   // Merge a byte, then eight shift steps.
   always_comb begin
      crcNext = crcReg ^ {8'h00, byteIn};              // RULE4
      for (int i = 0; i < 8; i++) begin                // RULE6
         if (crcNext[0]) begin
            crcNext = (crcNext >> 1) ^ CRC_POLY;        // RULE5
         end else begin
            crcNext = crcNext >> 1;                     // RULE5
         end
      end
   end

   // Clear wins, so each frame starts at ones.
   always_ff @(posedge clock) begin
      if (rst || clear) begin
         crcReg <= CRC_INIT;                           // RULE3
      end else if (byteValid) begin
         crcReg <= crcNext;
      end
   end

endmodule

//--- src/mbs_frame_engine.sv
// Function
// RULE1 - Frames end with 16-bit check over bytes
// RULE2 - Check sent low byte first, high second
// RULE3 - Check register starts each frame at ones
// RULE4 - Each byte XORed into low check byte
// RULE5 - Shift right, fold 0xA001 when one out
// RULE6 - Eight shift steps per byte, result is check
// RULE7 - Read coils request: addr, 01, start, count, check
// RULE8 - Read coils reply: addr, 01, count, bits, check
// RULE9 - First requested coil in bit zero
// RULE10 - Coil failures answer 0x81 or 0x85 exception
// RULE11 - Register failures answer 0x83 or 0x90 exception
// RULE12 - Force coil request: addr, 05, coil, value, check
// RULE13 - FF00 sets, 0000 clears, others leave coil
// RULE14 - Successful force reply echoes the request
// RULE15 - Read registers request: count one to thirty-two
// RULE16 - Read registers reply: byte count twice registers
// RULE17 - Float spans two registers, MSB first
// RULE18 - Write registers request carries twice-n data bytes
// RULE19 - Write reply echoes address, count, fresh check
// RULE20 - Act only on own address, 1 to 200
// RULE21 - Frames separated by gap over 3.5 chars
// RULE22 - Eight data bits, optional parity, set baud
// RULE23 - Bad check frames dropped without reply
// RULE24 - Unknown function answered with exception 01
module mbs_frame_engine import mbs_pkg::*; (
   input  wire logic         clock,     // System clock, 50 MHz.
   input  wire logic         rst,       // Synchronous reset, active high.
   input  wire logic [7:0]   devAddr,   // Configured slave address.
   input  wire mbs_parity_t  parityMode,// Character parity setting.
   input  wire logic         bitTick,   // One pulse per bit time.
   input  wire logic         rxValid,   // Received character strobe.
   input  wire logic [7:0]   rxByte,    // Received character.
   input  wire logic         rxErr,     // Parity or framing error.
   input  wire logic         txReady,   // Transmitter takes txByte.
   output logic              txValid,   // Reply byte waiting.
   output logic      [7:0]   txByte,    // Reply byte.
   output logic              accReq,    // One-cycle access request.
   output mbs_acc_req_t      accCmd,    // Access command, held.
   input  wire mbs_acc_rsp_t accRsp,    // Map answer.
   output logic              frameDrop, // Frame discarded pulse.
   output logic              replyDone  // Reply fully sent pulse.
);

   mbs_state_t  state_reg;
   mbs_kind_t   kind_reg;
   logic [7:0]  excCode_reg;
   logic [4:0]  idx_reg;
   logic [6:0]  rxCount_reg;
   logic        rxBad_reg;
   logic [5:0]  gapCount_reg;
   logic [6:0]  txIdx_reg;
   logic [15:0] coilBits_reg;
   logic [7:0]  rxBuf [0:RX_BUF_LEN-1];
   logic [15:0] regData [0:31];
   logic [15:0] rxCrc;
   logic [15:0] txCrc;
   logic [5:0]  gapLimit;
   logic        frameEnd;
   logic        rxTake;
   logic [7:0]  func;
   logic [15:0] startAddr;
   logic [15:0] cnt;
   logic [15:0] forceVal;
   logic        frameOk;
   logic        funcKnown;
   logic        shapeOk;
   logic        forceValid;
   mbs_kind_t   reqKind;
   logic [4:0]  lastIdx;
   logic [6:0]  dataLen;
   logic [6:0]  replyLen;
   logic [6:0]  txLast;
   logic        txTake;
   logic [7:0]  payByte;
   logic [6:0]  dataOff;
   logic [6:0]  wrPos;

   // Request fields come from the buffer.
   assign func      = rxBuf[POS_FUNC];
   assign startAddr = {rxBuf[POS_START_HI], rxBuf[POS_START_LO]};
   assign cnt       = {rxBuf[POS_CNT_HI], rxBuf[POS_CNT_LO]};
   assign forceVal  = cnt;
   assign forceValid = (forceVal == COIL_ON) || (forceVal == COIL_OFF);

   // Parity lengthens the idle gap.
   assign gapLimit = (parityMode == PAR_NONE) ? GAP_TICKS_PLAIN
                                              : GAP_TICKS_PARITY; // RULE22
   assign frameEnd = (rxCount_reg != 7'h00) && (gapCount_reg == gapLimit);
   assign rxTake   = (state_reg == ST_RECV) && rxValid
                     && (rxCount_reg != RX_BUF_LEN);

   // Receive: store bytes, time the gap after the last.
   // Bytes during processing or reply are dropped:
   // the half-duplex master waits for the reply.
   always_ff @(posedge clock) begin
      if (rst || state_reg != ST_RECV) begin
         rxCount_reg  <= 7'h00;
         rxBad_reg    <= 1'b0;
         gapCount_reg <= 6'h00;
      end else if (rxValid) begin
         gapCount_reg <= 6'h00;                                   // RULE21
         if (rxTake) begin
            rxCount_reg <= rxCount_reg + 7'h01;
         end else begin
            rxBad_reg <= 1'b1;
         end
         if (rxErr) begin
            rxBad_reg <= 1'b1;
         end
      end else if (bitTick && rxCount_reg != 7'h00
                   && gapCount_reg != gapLimit) begin
         gapCount_reg <= gapCount_reg + 6'h01;                    // RULE21
      end
   end

   // Data only, so no reset.
   always_ff @(posedge clock) begin
      if (rxTake) begin
         rxBuf[rxCount_reg] <= rxByte;
      end
   end

   // Check over all bytes, check bytes included.
   mbs_crc16 rxCheck (
      .clock     (clock),
      .rst       (rst),
      .clear     (state_reg != ST_RECV),
      .byteValid (rxTake),
      .byteIn    (rxByte),
      .crcReg    (rxCrc)
   );

   // Accept: good check, length, own address.
   assign frameOk = !rxBad_reg
                    && (rxCrc == CRC_RESIDUE)                    // RULE23
                    && (rxCount_reg >= MIN_FRAME_LEN)
                    && (devAddr >= DEV_ADDR_MIN)
                    && (devAddr <= DEV_ADDR_MAX)
                    && (rxBuf[POS_ADDR] == devAddr);              // RULE20

   // Function decode and request shape checks.
   always_comb begin
      funcKnown = 1'b1;
      shapeOk   = 1'b0;
      reqKind   = RK_EXC;
      wrPos     = WR_HDR_LEN + {cnt[5:0], 1'b0};
      case (func)
         FC_RD_COILS: begin
            reqKind = RK_RC;
            shapeOk = (rxCount_reg == FIXED_REQ_LEN)
                      && (cnt >= CNT_MIN) && (cnt <= MAX_COILS); // RULE7
         end
         FC_FORCE_COIL: begin
            reqKind = RK_FS;
            shapeOk = (rxCount_reg == FIXED_REQ_LEN);             // RULE12
         end
         FC_RD_REGS: begin
            reqKind = RK_RR;
            shapeOk = (rxCount_reg == FIXED_REQ_LEN)
                      && (cnt >= CNT_MIN) && (cnt <= MAX_REGS);  // RULE15
         end
         FC_WR_REGS: begin
            reqKind = RK_WR;
            shapeOk = (cnt >= CNT_MIN) && (cnt <= MAX_REGS)
                      && (rxBuf[POS_BYTECNT] == {1'b0, wrPos - WR_HDR_LEN})
                      && (rxCount_reg == wrPos);                  // RULE18
         end
         default: begin
            funcKnown = 1'b0;
         end
      endcase
   end

   // A coil write is one access; others run the count.
   assign lastIdx = (kind_reg == RK_FS) ? 5'h00 : 5'(cnt - CNT_MIN);

   // Check, walk the accesses, then reply.
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg   <= ST_RECV;
         kind_reg    <= RK_EXC;
         excCode_reg <= 8'h00;
         idx_reg     <= 5'h00;
      end else begin
         case (state_reg)
            ST_RECV: begin
               if (frameEnd) begin
                  state_reg <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               idx_reg <= 5'h00;
               if (!frameOk) begin
                  state_reg <= ST_RECV;                           // RULE23
               end else if (!funcKnown) begin
                  kind_reg    <= RK_EXC;
                  excCode_reg <= EXC_ILL_FUNC;                    // RULE24
                  state_reg   <= ST_SEND;
               end else if (!shapeOk) begin
                  kind_reg    <= RK_EXC;
                  excCode_reg <= EXC_ILL_VALUE;
                  state_reg   <= ST_SEND;
               end else if (reqKind == RK_FS && !forceValid) begin
                  kind_reg  <= RK_FS;                             // RULE13
                  state_reg <= ST_SEND;
               end else begin
                  kind_reg  <= reqKind;
                  state_reg <= ST_ACCESS;
               end
            end
            ST_ACCESS: begin
               state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (accRsp.ack) begin
                  if (accRsp.err) begin
                     kind_reg    <= RK_EXC;                 // RULE10 RULE11
                     excCode_reg <= accRsp.code;
                     state_reg   <= ST_SEND;
                  end else if (idx_reg == lastIdx) begin
                     state_reg <= ST_SEND;
                  end else begin
                     idx_reg   <= idx_reg + 5'h01;
                     state_reg <= ST_ACCESS;
                  end
               end
            end
            ST_SEND: begin
               if (txTake && txIdx_reg == txLast) begin
                  state_reg <= ST_RECV;
               end
            end
            default: begin
               state_reg <= ST_RECV;
            end
         endcase
      end
   end

   // Access command to the map.
   always_ff @(posedge clock) begin
      if (rst) begin
         accReq <= 1'b0;
         accCmd <= '0;
      end else begin
         accReq <= (state_reg == ST_ACCESS);
         if (state_reg == ST_ACCESS) begin
            accCmd.addr  <= startAddr + {11'h000, idx_reg};
            accCmd.coil  <= (kind_reg == RK_RC) || (kind_reg == RK_FS);
            accCmd.write <= (kind_reg == RK_FS) || (kind_reg == RK_WR);
            if (kind_reg == RK_FS) begin
               accCmd.wdata <= {15'h0000, forceVal == COIL_ON};   // RULE13
            end else begin
               accCmd.wdata <= {rxBuf[POS_WDATA + {1'b0, idx_reg, 1'b0}],
                  rxBuf[POS_WDATA + {1'b0, idx_reg, 1'b0} + 7'h01]};
            end
         end
      end
   end

   // Read results; unrequested coil bits stay zero.
   always_ff @(posedge clock) begin
      if (rst || state_reg == ST_CHECK) begin
         coilBits_reg <= 16'h0000;
      end else if (state_reg == ST_WAIT && accRsp.ack && !accRsp.err
                   && kind_reg == RK_RC) begin
         coilBits_reg[idx_reg[3:0]] <= accRsp.rdata[0];           // RULE9
      end
   end

   always_ff @(posedge clock) begin
      if (state_reg == ST_WAIT && accRsp.ack && !accRsp.err
          && kind_reg == RK_RR) begin
         regData[idx_reg] <= accRsp.rdata;
      end
   end

   // Data bytes of a read reply.
   assign dataLen = (kind_reg == RK_RR) ? {cnt[5:0], 1'b0}       // RULE16
                  : ((cnt > COILS_PER_BYTE) ? 7'h02 : 7'h01);     // RULE8
   always_comb begin
      case (kind_reg)
         RK_RC, RK_RR: replyLen = RSP_HDR_LEN + dataLen;
         RK_FS, RK_WR: replyLen = RSP_ECHO_LEN;             // RULE14 RULE19
         default:      replyLen = RSP_HDR_LEN;
      endcase
   end
   assign txLast  = replyLen + CRC_LEN;
   assign txTake  = !txValid || txReady;
   assign dataOff = txIdx_reg - RSP_HDR_LEN;

   // Payload byte at the send position.
   always_comb begin
      payByte = 8'h00;
      if (txIdx_reg == POS_ADDR) begin
         payByte = rxBuf[POS_ADDR];
      end else if (kind_reg == RK_FS || kind_reg == RK_WR) begin
         payByte = rxBuf[txIdx_reg];                       // RULE14 RULE19
      end else if (txIdx_reg == POS_FUNC) begin
         payByte = (kind_reg == RK_EXC) ? (func | FC_EXC_FLAG)    // RULE10
                                        : func;                   // RULE11
      end else if (txIdx_reg == POS_START_HI) begin
         payByte = (kind_reg == RK_EXC) ? excCode_reg : {1'b0, dataLen};
      end else if (kind_reg == RK_RC) begin
         payByte = dataOff[0] ? coilBits_reg[15:8] : coilBits_reg[7:0];
      end else begin
         // High byte first keeps a float MSB first.
         payByte = dataOff[0] ? regData[dataOff[5:1]][7:0]
                              : regData[dataOff[5:1]][15:8];      // RULE17
      end
   end

   // Check over the reply as it is loaded.
   mbs_crc16 txCheck (
      .clock     (clock),
      .rst       (rst),
      .clear     (state_reg != ST_SEND),
      .byteValid ((state_reg == ST_SEND) && txTake
                  && (txIdx_reg < replyLen)),
      .byteIn    (payByte),
      .crcReg    (txCrc)
   );

   // Send; the check trails, low byte first.
   always_ff @(posedge clock) begin
      if (rst || state_reg != ST_SEND) begin
         txValid   <= 1'b0;
         txByte    <= 8'h00;
         txIdx_reg <= 7'h00;
      end else if (txTake) begin
         if (txIdx_reg == txLast) begin
            txValid <= 1'b0;
         end else begin
            txValid   <= 1'b1;
            txIdx_reg <= txIdx_reg + 7'h01;
            if (txIdx_reg < replyLen) begin
               txByte <= payByte;
            end else if (txIdx_reg == replyLen) begin
               txByte <= txCrc[7:0];                        // RULE1 RULE2
            end else begin
               txByte <= txCrc[15:8];                             // RULE2
            end
         end
      end
   end

   // Event pulses.
   always_ff @(posedge clock) begin
      if (rst) begin
         frameDrop <= 1'b0;
         replyDone <= 1'b0;
      end else begin
         frameDrop <= (state_reg == ST_CHECK) && !frameOk;
         replyDone <= (state_reg == ST_SEND) && txTake
                      && (txIdx_reg == txLast);
      end
   end

endmodule

//--- src/mbs_pkg.sv
package mbs_pkg;

   // Check calculation constants.
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'ha001;
   // Running the check over a frame and its own check bytes leaves zero.
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   // Function codes and the exception flag.
   localparam logic [7:0] FC_RD_COILS   = 8'h01;
   localparam logic [7:0] FC_RD_REGS    = 8'h03;
   localparam logic [7:0] FC_FORCE_COIL = 8'h05;
   localparam logic [7:0] FC_WR_REGS    = 8'h10;
   localparam logic [7:0] FC_EXC_FLAG   = 8'h80;

   // Exception codes.
   localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
   localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
   localparam logic [7:0] EXC_DEV_FAIL  = 8'h04;

   // Force values of a single coil.
   localparam logic [15:0] COIL_ON  = 16'hff00;
   localparam logic [15:0] COIL_OFF = 16'h0000;

   // Valid range of the configured slave address.
   localparam logic [7:0] DEV_ADDR_MIN = 8'h01;
   localparam logic [7:0] DEV_ADDR_MAX = 8'hc8;

   // Item count limits.
   localparam logic [15:0] CNT_MIN       = 16'h0001;
   localparam logic [15:0] MAX_COILS     = 16'h0010;
   localparam logic [15:0] MAX_REGS      = 16'h0020;
   localparam logic [15:0] COILS_PER_BYTE = 16'h0008;

   // Request byte positions.
   localparam logic [6:0] POS_ADDR     = 7'h00;
   localparam logic [6:0] POS_FUNC     = 7'h01;
   localparam logic [6:0] POS_START_HI = 7'h02;
   localparam logic [6:0] POS_START_LO = 7'h03;
   localparam logic [6:0] POS_CNT_HI   = 7'h04;
   localparam logic [6:0] POS_CNT_LO   = 7'h05;
   localparam logic [6:0] POS_BYTECNT  = 7'h06;
   localparam logic [6:0] POS_WDATA    = 7'h07;

   // Frame lengths in bytes; request lengths include the check bytes, reply lengths do not.
   localparam logic [6:0] RX_BUF_LEN    = 7'h49;
   localparam logic [6:0] MIN_FRAME_LEN = 7'h04;
   localparam logic [6:0] FIXED_REQ_LEN = 7'h08;
   localparam logic [6:0] WR_HDR_LEN    = 7'h09;
   localparam logic [6:0] RSP_HDR_LEN   = 7'h03;
   localparam logic [6:0] RSP_ECHO_LEN  = 7'h06;
   localparam logic [6:0] CRC_LEN       = 7'h02;

   // Idle gap in bit times: first whole bit time over 3.5 characters of 11 or 10 bits.
   localparam logic [5:0] GAP_TICKS_PARITY = 6'h27;
   localparam logic [5:0] GAP_TICKS_PLAIN  = 6'h24;

   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ODD  = 2'b01,
      PAR_EVEN = 2'b10
   } mbs_parity_t;

   typedef enum logic [2:0] {
      ST_RECV   = 3'b000,
      ST_CHECK  = 3'b001,
      ST_ACCESS = 3'b010,
      ST_WAIT   = 3'b011,
      ST_SEND   = 3'b100
   } mbs_state_t;

   typedef enum logic [2:0] {
      RK_EXC = 3'b000,
      RK_RC  = 3'b001,
      RK_FS  = 3'b010,
      RK_RR  = 3'b011,
      RK_WR  = 3'b100
   } mbs_kind_t;

   // One access to the coil and register map.
   typedef struct packed {
      logic        write;
      logic        coil;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mbs_acc_req_t;

   // The map's answer to one access.
   typedef struct packed {
      logic        ack;
      logic        err;
      logic [7:0]  code;
      logic [15:0] rdata;
   } mbs_acc_rsp_t;

endpackage

//--- verification/mbs_frame_engine_sva.sv
// Interface checks of the frame engine.
module mbs_frame_engine_sva import mbs_pkg::*; (
   input wire logic         clock,     // System clock.
   input wire logic         rst,       // Reset.
   input wire logic [7:0]   devAddr,   // Slave address.
   input wire logic         txReady,   // Byte taken.
   input wire logic         txValid,   // Byte waiting.
   input wire logic [7:0]   txByte,    // Reply byte.
   input wire logic         accReq,    // Access pulse.
   input wire mbs_acc_req_t accCmd,    // Access command.
   input wire logic         frameDrop, // Drop pulse.
   input wire logic         replyDone  // Reply end pulse.
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // A byte waits on a stall and leaves on take.
   sequence s_wait; txValid && !txReady; endsequence
   sequence s_take; txValid && txReady; endsequence

   property p_hold; s_wait |=> txValid && $stable(txByte); endproperty
   a_hold: assert property (p_hold)
      else $error("Byte changed while stalled.");
   property p_end; s_take ##1 !txValid |-> ##[0:1] replyDone; endproperty
   a_end: assert property (p_end)
      else $error("No done pulse.");
   property p_first; $rose(txValid) |-> txByte == devAddr; endproperty
   a_first: assert property (p_first)
      else $error("Reply lacks own address.");
   property p_gap; accReq |=> !accReq [*2]; endproperty
   a_gap: assert property (p_gap)
      else $error("Access too soon.");
   property p_force;
      accReq && accCmd.coil && accCmd.write |-> accCmd.wdata[15:1] == 15'h0;
   endproperty
   a_force: assert property (p_force)
      else $error("Wide coil write.");
   property p_drop; frameDrop |-> !txValid ##1 !txValid [*8]; endproperty
   a_drop: assert property (p_drop)
      else $error("Reply to dropped frame.");
   property p_addr;
      devAddr == 8'h00 || devAddr > DEV_ADDR_MAX |-> !accReq && !txValid;
   endproperty
   a_addr: assert property (p_addr)
      else $error("Acted on bad address.");
   property p_rst;
      $fell(rst) |-> !txValid && !accReq && !frameDrop && !replyDone;
   endproperty
   a_rst: assert property (p_rst)
      else $error("Outputs busy after reset.");
endmodule

bind mbs_frame_engine mbs_frame_engine_sva chk_u (
   .clock(clock), .rst(rst), .devAddr(devAddr), .txReady(txReady),
   .txValid(txValid), .txByte(txByte), .accReq(accReq), .accCmd(accCmd),
   .frameDrop(frameDrop), .replyDone(replyDone));

//--- verification/mbs_frame_engine_test.sv
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("[ERR] t=%0t got %h expected %h", $time, got, exp); \
      end \
   end

module mbs_frame_engine_test import mbs_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] ADR = 8'hc8;

   logic         clock, rst, slow, bitTick, rxValid, rxErr;
   logic         txReady, txValid, accReq, frameDrop, replyDone;
   logic [7:0]   devAddr, rxByte, txByte;
   logic [1:0]   ackDly;
   logic [15:0]  coilMem;
   logic [15:0]  regMem[64];
   mbs_parity_t  parityMode;
   mbs_acc_req_t accCmd;
   mbs_acc_rsp_t accRsp, rsp;
   int           n_errors = 0;
   int           cmp_count = 0;

   mbs_frame_engine dut_u (
      .clock(clock), .rst(rst), .devAddr(devAddr), .parityMode(parityMode),
      .bitTick(bitTick), .rxValid(rxValid), .rxByte(rxByte), .rxErr(rxErr),
      .txReady(txReady), .txValid(txValid), .txByte(txByte),
      .accReq(accReq), .accCmd(accCmd), .accRsp(accRsp),
      .frameDrop(frameDrop), .replyDone(replyDone));

   mbs_master_model master_u (
      .clock(clock), .slow(slow), .bitTick(bitTick), .rxValid(rxValid),
      .rxByte(rxByte), .rxErr(rxErr), .txReady(txReady),
      .txValid(txValid), .txByte(txByte));

   // Map stand-in: acks three edges after a request; address ee.. fails.
   always @(posedge clock) begin
      ackDly <= {ackDly[0], accReq};
      rsp = '0;
      rsp.ack = ackDly[1];
      if (ackDly[1] && accCmd.addr[15:8] == 8'hee) begin
         rsp.err = 1'b1;
         rsp.code = EXC_ILL_ADDR;
      end else if (ackDly[1] && accCmd.coil) begin
         if (accCmd.write) coilMem[accCmd.addr[3:0]] = accCmd.wdata[0];
         rsp.rdata = {15'h0000, coilMem[accCmd.addr[3:0]]};
      end else if (ackDly[1]) begin
         if (accCmd.write) regMem[accCmd.addr[5:0]] = accCmd.wdata;
         rsp.rdata = regMem[accCmd.addr[5:0]];
      end
      accRsp <= rsp;
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Request, then the whole reply with its check.
   task automatic xfer(input logic [7:0] req[$], input logic [7:0] exp[$],
                       input int space);
      logic [15:0] c;
      int n;
      master_u.rspQ.delete();
      master_u.send(req, space, 1'b1, -1);
      c = master_u.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      n = 0;
      while (replyDone !== 1'b1) begin
         @(negedge clock);
         n++;
         if (n > 3000) begin
            n_errors++;
            $display("[ERR] t=%0t no reply", $time);
            give_verdict();
         end
      end
      `CHK(master_u.rspQ.size(), exp.size())
      foreach (exp[i]) `CHK(master_u.rspQ[i], exp[i])
   endtask

   // A frame that must be dropped: no reply.
   task automatic silent(input logic [7:0] req[$], input int space,
                         input bit goodCrc, input int errAt);
      int drops;
      drops = 0;
      master_u.rspQ.delete();
      master_u.send(req, space, goodCrc, errAt);
      repeat (400) begin
         @(negedge clock);
         if (frameDrop === 1'b1) drops++;
      end
      `CHK(drops > 0, 1'b1)
      `CHK(master_u.rspQ.size(), 0)
   endtask

   task automatic t_coils();
      logic [7:0] q[$];
      q = '{8'h01,8'h01,8'h05,8'h10,8'h00,8'h01};
      `CHK(master_u.crc16(q), 16'hc3fc)
      coilMem = 16'h8c35;
      xfer('{ADR,FC_RD_COILS,8'h00,8'h00,8'h00,8'h10},
           '{ADR,FC_RD_COILS,8'h02,8'h35,8'h8c}, 10);
      xfer('{ADR,FC_RD_COILS,8'h00,8'h02,8'h00,8'h03},
           '{ADR,FC_RD_COILS,8'h01,8'h05}, 10);
   endtask

   // Force on, invalid, off; each echoed, read back after the invalid and the off.
   task automatic t_force();
      logic [7:0] q[$];
      logic [7:0] r[$];
      q = '{ADR,FC_FORCE_COIL,8'h00,8'h09,8'hff,8'h00};
      r = '{ADR,FC_RD_COILS,8'h00,8'h09,8'h00,8'h01};
      xfer(q, q, 10);
      q[4] = 8'h12;
      xfer(q, q, 10);
      xfer(r, '{ADR,FC_RD_COILS,8'h01,8'h01}, 10);
      q[4] = 8'h00;
      xfer(q, q, 10);
      xfer(r, '{ADR,FC_RD_COILS,8'h01,8'h00}, 10);
   endtask

   // Stalling master; a 37-bit gap splits only without parity.
   task automatic t_regs();
      logic [7:0] r[$];
      slow <= 1'b1;
      parityMode <= PAR_EVEN;
      xfer('{ADR,FC_WR_REGS,8'h00,8'h04,8'h00,8'h02,8'h04,8'h41,8'h20,
             8'h00,8'h2a}, '{ADR,FC_WR_REGS,8'h00,8'h04,8'h00,8'h02},
           10);
      `CHK(regMem[5], 16'h002a)
      r = '{ADR,FC_RD_REGS,8'h00,8'h04,8'h00,8'h02};
      xfer(r, '{ADR,FC_RD_REGS,8'h04,8'h41,8'h20,8'h00,8'h2a},
           37);
      slow <= 1'b0;
      parityMode <= PAR_NONE;
      silent(r, 37, 1'b1, -1);
   endtask

   task automatic t_errors();
      xfer('{ADR,8'h07,8'h00,8'h00,8'h00,8'h01},
           '{ADR,8'h87,EXC_ILL_FUNC}, 10);
      xfer('{ADR,FC_RD_COILS,8'h00,8'h00,8'h00,8'h11},
           '{ADR,8'h81,EXC_ILL_VALUE}, 10);
      xfer('{ADR,FC_FORCE_COIL,8'hee,8'h00,8'hff,8'h00},
           '{ADR,8'h85,EXC_ILL_ADDR}, 10);
      xfer('{ADR,FC_RD_REGS,8'h00,8'h00,8'h00,8'h21},
           '{ADR,8'h83,EXC_ILL_VALUE}, 10);
      xfer('{ADR,FC_WR_REGS,8'hee,8'h00,8'h00,8'h01,8'h02,8'h12,8'h34},
           '{ADR,8'h90,EXC_ILL_ADDR}, 10);
   endtask

   task automatic t_drops();
      logic [7:0] r[$];
      r = '{ADR,FC_RD_REGS,8'h00,8'h00,8'h00,8'h01};
      silent(r, 10, 1'b0, -1);
      silent(r, 10, 1'b1, 3);
      r[0] = 8'h01;
      silent(r, 10, 1'b1, -1);
      r[0] = 8'h00;
      devAddr <= 8'h00;
      silent(r, 10, 1'b1, -1);
      devAddr <= ADR;
      r[0] = ADR;
      xfer(r, '{ADR,FC_RD_REGS,8'h02,8'h00,8'hff}, 10);
   endtask

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Each register holds its index and its inverse.
   initial begin
      rst = 1'b1;
      {slow, ackDly, coilMem} = '0;
      accRsp = '0;
      devAddr = ADR;
      parityMode = PAR_NONE;
      foreach (regMem[i]) regMem[i] = {8'(i), ~8'(i)};
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      t_coils();
      t_force();
      t_regs();
      t_errors();
      t_drops();
      give_verdict();
   end
endmodule

//--- verification/mbs_master_model.sv
// Bus master stand-in: bit-rate characters out, reply bytes in.
module mbs_master_model import mbs_pkg::*; (
   input  wire logic       clock,   // System clock.
   input  wire logic       slow,    // Stall every other cycle.
   output logic            bitTick, // One pulse per bit time.
   output logic            rxValid, // Character strobe.
   output logic      [7:0] rxByte,  // Character.
   output logic            rxErr,   // Broken character flag.
   output logic            txReady, // Reply byte taken.
   input  wire logic       txValid, // Reply byte waiting.
   input  wire logic [7:0] txByte   // Reply byte.
);
   logic [1:0] divCnt;
   logic [7:0] rspQ[$];

   initial {divCnt, bitTick, rxValid, rxByte, rxErr, txReady} = '0;

   // Four clocks a bit keeps frames short.
   always @(posedge clock) begin
      divCnt <= divCnt + 2'h1;
      bitTick <= (divCnt == 2'h3);
      txReady <= slow ? ~txReady : 1'b1;
      if (txValid && txReady) begin
         rspQ.push_back(txByte);
      end
   end

   // Check value over a byte list.
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hffff;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
         end
      end
      return c;
   endfunction

   // space: bit times before each byte; errAt: broken byte.
   task automatic send(input logic [7:0] q[$], input int space,
                       input bit goodCrc, input int errAt);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0000, !goodCrc};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i]) begin
         repeat (space * 4) @(posedge clock);
         rxValid <= 1'b1;
         rxByte <= q[i];
         rxErr <= (i == errAt);
         @(posedge clock);
         rxValid <= 1'b0;
         rxByte <= ~q[i];
         rxErr <= 1'b0;
      end
   endtask
endmodule
